// >>> src/urx_core.sv
// Overview of operation
// RL1 - Standby bit set: receiver sleeps and all receiver interrupts stay off.
// RL2 - Address-mark wake: character with MSB one clears the standby bit.
// RL3 - The waking address character is delivered and sets receive-full.
// RL4 - Idle-line wake: an idle character clears the standby bit.
// RL5 - The waking idle character sets neither idle nor receive-full.
// RL6 - Idle-type bit picks idle counting after start bit or stop bit.
// RL7 - Idle wake mode: standby set on an idle line wakes again.
// RL8 - Character into buffer sets receive-full; enabled, it interrupts.
// RL9 - Idle flag after 10 or 11 ones; interrupts when enabled.
// RL10 - Character done while buffer full: overrun, old kept, new lost.
// RL11 - Each error flag interrupts only with its own enable set.
// RL12 - Sample disagreement on start, data or stop bit sets noise.
// RL13 - A zero where the stop bit belongs sets framing error.
// RL14 - Parity mismatch under odd or even setting sets parity error.
// RL15 - Nine-bit stop samples end ten bit times plus ten RT cycles.
// RL16 - Runs in wait mode; enabled requests can end wait mode.
// RL17 - Stop mode halts the block with all registers preserved.
// RL18 - Break clear-enable set: flags cleared in break stay cleared.
// RL19 - Break clear-enable clear: accesses in break leave flags unchanged.
// RL20 - Two-step clear armed before break holds; second step clears.
// RL21 - Enabled module forces transmit pin output, receive pin input.
// RL22 - Receive line sampled on an RT clock at sixteen times baud.
// RL23 - Stop bit by majority of RT8..RT10; mixed noise, zero framing.
// RL24 - Wake-method bit: one is address mark, zero is idle line.
// RL25 - Length bit: zero for eight data bits, one for nine.
// RL26 - Remote transmitter keeps baud close enough for stop samples.

`timescale 1ns/1ps

module urx_core
  import urx_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        receive_pin_i,
  input  wire logic [1:0]  port_dir_i,
  input  wire logic        stop_mode_i,
  input  wire logic        debug_break_i,
  output logic             rx_irq_o,
  output logic             err_irq_o,
  output logic             wait_wake_o,
  output logic             transmit_pin_oe_o,
  output logic             receive_pin_oe_o
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Majority vote of three samples.
  function automatic logic maj3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : maj3

  // High when the three samples do not all agree.
  function automatic logic mixed3(input logic [2:0] s);
    return (|s) & ~(&s);
  endfunction : mixed3

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [6:0]        ctrl1;
  logic              full_ie;
  logic              idle_ie;
  logic              rx_enable;
  logic              rx_standby_bit;
  logic [3:0]        ctrl3;
  logic              break_clear_enable;
  logic [BAUD_W-1:0] baud_div;
  logic [BAUD_W-1:0] baud_cnt;
  urx_flags_t        flg;
  urx_flags_t        armed;
  logic [8:0]        serial_data_buffer;
  logic              rx_meta;
  logic              rx_sync;
  urx_state_t        state;
  logic [3:0]        rt_cnt;
  logic [3:0]        bit_idx;
  logic [1:0]        smp;
  logic [1:0]        ones;
  logic              nz_acc;
  logic [8:0]        shreg;
  logic [7:0]        idle_cnt;
  logic              idle_seen;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------

  // The access takes effect on the edge where ack is seen high.
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire bus_do  = bus_req & wb_ack_o;
  wire wr_lo   = bus_do & wb_we_i & wb_sel_i[0];
  wire wr_hi   = bus_do & wb_we_i & wb_sel_i[1];
  wire rd_do   = bus_do & ~wb_we_i;
  wire hit_c1  = wb_adr_i == ADR_CTRL1;
  wire hit_c2  = wb_adr_i == ADR_CTRL2;
  wire hit_c3  = wb_adr_i == ADR_CTRL3;
  wire hit_st  = wb_adr_i == ADR_STAT;
  wire hit_dt  = wb_adr_i == ADR_DATA;
  wire hit_bk  = wb_adr_i == ADR_BRK;
  wire hit_bd  = wb_adr_i == ADR_BAUD;
  wire wr_c2   = wr_lo & hit_c2;

  // RL19 protected flags.
  // In a debug break, flag clearing is blocked unless software allows it.
  wire allow_clr = ~debug_break_i | break_clear_enable;
  // RL20 two-step clear.
  // Status read arms the clear, data read completes it.
  wire rd_stat   = rd_do & hit_st & allow_clr;
  wire rd_data   = rd_do & hit_dt & allow_clr;

  // Read data multiplexer; unmapped addresses read as zero.
  wire [31:0] rdata =
    hit_c1 ? {25'h0, ctrl1} :
    hit_c2 ? {26'h0, full_ie, idle_ie, 1'b0, rx_enable,
              rx_standby_bit, 1'b0} :
    hit_c3 ? {28'h0, ctrl3} :
    hit_st ? {26'h0, flg} :
    hit_dt ? {23'h0, serial_data_buffer} :
    hit_bk ? {24'h0, break_clear_enable, 7'h0} :
    hit_bd ? {16'h0, baud_div} : 32'h0;

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  wire module_enable_bit   = ctrl1[C1_ENABLE];
  wire nine_bit            = ctrl1[C1_NINE];
  wire wake_addr           = ctrl1[C1_WAKE];
  wire idle_count_type_bit = ctrl1[C1_IDLE_TY];
  wire parity_en           = ctrl1[C1_PAR_EN];
  wire parity_odd          = ctrl1[C1_PAR_ODD];
  wire rx_on               = module_enable_bit & rx_enable;

  // RL17 stop freeze.
  // Stop mode holds the divider, so the receiver sees no RT tick.
  wire run     = module_enable_bit & ~stop_mode_i;
  // RL22 RT clock.
  // One RT tick every baud_div+1 bus clocks, sixteen per bit.
  wire rt_tick = run & (baud_cnt == baud_div);

  // ----------------------------------------------------------------
  // Receiver decisions
  // ----------------------------------------------------------------
  wire [2:0] trio    = {smp, rx_sync};
  // RL23 majority vote.
  wire       bit_val = maj3(trio);
  wire       in_frm  = state == URX_FRAME;
  wire       start_edge = rt_tick & (state == URX_SEARCH)
                          & (ones == 2'h3) & ~rx_sync;
  wire       capture = rt_tick & (
                 ((state == URX_START) &
                  ((rt_cnt == RT_S3) | (rt_cnt == RT_S5))) |
                 (in_frm & ((rt_cnt == RT_S8) | (rt_cnt == RT_S9))));
  wire       decide  = rt_tick & in_frm & (rt_cnt == RT_S10);
  // RL25 character length.
  // RL15 stop position.
  wire [3:0] stop_idx = nine_bit ? STOP_IDX_9 : STOP_IDX_8;
  wire       done     = decide & (bit_idx == stop_idx);
  wire       shift    = decide & (bit_idx != 4'h0) & ~done;
  // RL12 noise detect.
  // A start bit that passes the RT7 check is still taken with any high sample, but flagged.
  wire       nz_now   = mixed3(trio) | ((bit_idx == 4'h0) & bit_val);
  wire       nz_total = nz_acc | nz_now;

  // Eight-bit characters sit one place high in the shift register.
  wire [8:0] data9 = nine_bit ? shreg : {1'b0, shreg[8:1]};
  wire       msb   = nine_bit ? data9[8] : data9[7];
  // RL14 parity check.
  wire       par_err = parity_en & ((^data9) != parity_odd);

  // RL24 wake method.
  // RL2 address wake.
  wire addr_wake = done & rx_standby_bit & wake_addr & msb;
  // RL3 address delivered.
  wire deliver   = done & (~rx_standby_bit | addr_wake);
  // RL10 overrun keeps buffer.
  wire load      = deliver & ~flg.rx_full;
  wire ovr       = deliver & flg.rx_full;

  // ----------------------------------------------------------------
  // Idle detection
  // ----------------------------------------------------------------

  // RL6 idle count start.
  // Counting after the stop bit avoids false idles inside a frame.
  wire       idle_ok   = ~idle_count_type_bit | (state == URX_SEARCH);
  // RL9 idle length.
  wire [7:0] idle_last = nine_bit ? IDLE_LAST_9 : IDLE_LAST_8;
  wire       idle_ev   = rt_tick & rx_on & rx_sync & idle_ok
                         & ~idle_seen & (idle_cnt == idle_last);
  // RL4 idle wake.
  // RL7 rewake on idle.
  wire idle_wake = rx_standby_bit & ~wake_addr & (idle_ev | idle_seen);
  // RL5 quiet wake.
  wire idle_set  = idle_ev & ~rx_standby_bit;

  // ----------------------------------------------------------------
  // Flag update
  // ----------------------------------------------------------------
  urx_flags_t flg_set;
  urx_flags_t flg_clr;
  urx_flags_t next_flg;

  // RL8 receive full.
  // RL13 framing error.
  assign flg_set  = {load, idle_set, ovr, load & nz_total,
                     load & ~bit_val, load & par_err};
  // RL18 clear in break.
  assign flg_clr  = rd_data ? armed : '0;
  // A hardware set in the clearing cycle wins over the clear.
  assign next_flg = flg_set | (flg & ~flg_clr);

  wire next_standby = wr_c2 ? wb_dat_i[C2_STANDBY]
                    : ((addr_wake | idle_wake) ? 1'b0 : rx_standby_bit);

  // RL1 standby quiet.
  // RL11 error enables.
  wire next_rx_irq  = ~rx_standby_bit &
                      ((flg.rx_full & full_ie) | (flg.idle & idle_ie));
  wire next_err_irq = ~rx_standby_bit &
                      (|({flg.overrun, flg.noise, flg.framing,
                          flg.parity} & ctrl3));

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------

  // Ack follows one cycle after the request and drops the next cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req & ~wb_ack_o) begin
        wb_dat_o <= rdata;
      end
    end
  end

  // Software registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl1              <= CTRL1_RST;
      full_ie            <= 1'b0;
      idle_ie            <= 1'b0;
      rx_enable          <= 1'b0;
      ctrl3              <= CTRL3_RST;
      break_clear_enable <= 1'b0;
      baud_div           <= BAUD_RST;
    end else begin
      if (wr_lo & hit_c1) begin
        ctrl1 <= wb_dat_i[6:0] & C1_WMASK;
      end
      if (wr_c2) begin
        full_ie <= wb_dat_i[C2_FULL_IE];
        idle_ie <= wb_dat_i[C2_IDLE_IE];
        // The receiver enable only takes a write while enabled.
        if (module_enable_bit) begin
          rx_enable <= wb_dat_i[C2_RX_EN];
        end
      end
      if (wr_lo & hit_c3) begin
        ctrl3 <= wb_dat_i[3:0];
      end
      if (wr_lo & hit_bk) begin
        break_clear_enable <= wb_dat_i[BRK_BREAK_CLEAR_ENABLE];
      end
      if (wr_lo & hit_bd) begin
        baud_div[7:0] <= wb_dat_i[7:0];
      end
      if (wr_hi & hit_bd) begin
        baud_div[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // Status flags, clear arming, standby and the receive buffer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flg                <= '0;
      armed              <= '0;
      rx_standby_bit     <= 1'b0;
      serial_data_buffer <= 9'h000;
    end else begin
      flg            <= next_flg;
      rx_standby_bit <= next_standby;
      if (rd_stat) begin
        armed <= flg;
      end else if (rd_data) begin
        armed <= '0;
      end
      if (load) begin
        serial_data_buffer <= data9;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------

  // Two-stage synchroniser for the receive pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= receive_pin_i;
      rx_sync <= rx_meta;
    end
  end

  // RT divider; a divisor change applies at once to the count already running.
  always_ff @(posedge clk_i) begin
    if (rst_i | ~module_enable_bit) begin
      baud_cnt <= '0;
    end else if (run) begin
      baud_cnt <= rt_tick ? '0 : baud_cnt + 1'b1;
    end
  end

  // Frame sequencer: search, start verify at RT3/5/7, then bits.
  always_ff @(posedge clk_i) begin
    if (rst_i | ~rx_on) begin
      state   <= URX_SEARCH;
      rt_cnt  <= 4'h0;
      bit_idx <= 4'h0;
      ones    <= 2'h0;
      nz_acc  <= 1'b0;
    end else if (rt_tick) begin
      rt_cnt <= rt_cnt + 4'h1;
      unique case (state)
        URX_SEARCH: begin
          if (start_edge) begin
            state  <= URX_START;
            rt_cnt <= 4'h0;
            nz_acc <= 1'b0;
          end else if (~rx_sync) begin
            ones <= 2'h0;
          end else if (ones != 2'h3) begin
            ones <= ones + 2'h1;
          end
        end
        URX_START: begin
          if (rt_cnt == RT_S7) begin
            if (bit_val) begin
              state <= URX_SEARCH;
              ones  <= 2'h0;
            end else begin
              state   <= URX_FRAME;
              bit_idx <= 4'h0;
              nz_acc  <= mixed3(trio);
            end
          end
        end
        URX_FRAME: begin
          if (rt_cnt == RT_LAST) begin
            bit_idx <= bit_idx + 4'h1;
          end
          if (decide) begin
            nz_acc <= nz_total;
          end
          // A break leaves no stop bit, so new ones must be seen.
          if (done) begin
            state <= URX_SEARCH;
            ones  <= bit_val ? 2'h3 : 2'h0;
          end
        end
        default: begin
          state <= URX_SEARCH;
        end
      endcase
    end
  end

  // Sample history and data shift register, LSB first.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      smp   <= 2'h0;
      shreg <= 9'h000;
    end else begin
      if (capture) begin
        smp <= {smp[0], rx_sync};
      end
      if (shift) begin
        shreg <= {bit_val, shreg[8:1]};
      end
    end
  end

  // Idle counter; any low sample restarts it.
  always_ff @(posedge clk_i) begin
    if (rst_i | ~rx_on) begin
      idle_cnt  <= 8'h00;
      idle_seen <= 1'b0;
    end else if (rt_tick) begin
      if (~rx_sync | ~idle_ok) begin
        idle_cnt <= 8'h00;
      end else if (~idle_seen) begin
        idle_cnt <= idle_cnt + 8'h01;
      end
      if (~rx_sync) begin
        idle_seen <= 1'b0;
      end else if (idle_ev) begin
        idle_seen <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // RL16 wait wake.
  // RL21 pin direction.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_irq_o          <= 1'b0;
      err_irq_o         <= 1'b0;
      wait_wake_o       <= 1'b0;
      transmit_pin_oe_o <= 1'b0;
      receive_pin_oe_o  <= 1'b0;
    end else begin
      rx_irq_o          <= next_rx_irq;
      err_irq_o         <= next_err_irq;
      wait_wake_o       <= next_rx_irq | next_err_irq;
      transmit_pin_oe_o <= module_enable_bit | port_dir_i[0];
      receive_pin_oe_o  <= ~module_enable_bit & port_dir_i[1];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Count of RT ticks since the start edge, read only by checks.
  logic [7:0] since_start;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      since_start <= 8'h00;
    end else if (start_edge) begin
      since_start <= 8'h01;
    end else if (rt_tick & (since_start != 8'hFF)) begin
      since_start <= since_start + 8'h01;
    end
  end

  sequence seq_addr_char;
    done && rx_standby_bit && wake_addr && msb && !flg.rx_full && !wr_c2;
  endsequence

  sequence seq_idle_wake;
    idle_ev && rx_standby_bit && !wake_addr && !flg.idle && !wr_c2;
  endsequence

  chk_standby_irq_off: assert property ( // RL1
    rx_standby_bit |=> !rx_irq_o && !err_irq_o && !wait_wake_o)
    else $error("Interrupt raised while in standby.");

  chk_addr_wake_ok: assert property ( // RL2
    seq_addr_char |=> !rx_standby_bit && flg.rx_full ##1 rx_irq_o == full_ie)
    else $error("Address mark did not wake and deliver.");

  chk_idle_wake_quiet: assert property ( // RL5
    seq_idle_wake |=> !rx_standby_bit && !flg.idle && !flg.rx_full)
    else $error("Waking idle character touched flags.");

  chk_full_load: assert property ( // RL8
    load |=> flg.rx_full && serial_data_buffer == $past(data9))
    else $error("Completed character not buffered.");

  chk_overrun_keep: assert property ( // RL10
    ovr |=> flg.overrun && $stable(serial_data_buffer))
    else $error("Overrun lost buffered character.");

  chk_err_irq_gate: assert property ( // RL11
    (({flg.overrun, flg.noise, flg.framing, flg.parity} & ctrl3) == 4'h0)
      |=> !err_irq_o)
    else $error("Error interrupt without enabled flag.");

  chk_frame_error: assert property ( // RL13
    load && !bit_val |=> flg.framing)
    else $error("Low stop bit did not set framing error.");

  chk_stop_time: assert property ( // RL15
    done |-> since_start == (nine_bit ? STOP_RT_9 : STOP_RT_8))
    else $error("Stop bit sampled at wrong RT count.");

  chk_stop_freeze: assert property ( // RL17
    stop_mode_i && rx_on |=> $stable(state) && $stable(rt_cnt))
    else $error("Receiver moved in stop mode.");

  chk_break_hold: assert property ( // RL19
    debug_break_i && !break_clear_enable |=> (~flg & $past(flg)) == 6'h00)
    else $error("Flag cleared during protected break.");

  chk_pin_dir: assert property ( // RL21
    module_enable_bit |=> transmit_pin_oe_o && !receive_pin_oe_o)
    else $error("Pin direction not forced while enabled.");

endmodule : urx_core

// >>> src/urx_pkg.sv
package urx_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses on the bus
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL1 = 8'h00; // serial_control_one
  localparam logic [7:0] ADR_CTRL2 = 8'h04; // serial_control_two
  localparam logic [7:0] ADR_CTRL3 = 8'h08; // serial_control_three
  localparam logic [7:0] ADR_STAT  = 8'h0C; // serial_status_one
  localparam logic [7:0] ADR_DATA  = 8'h10; // serial_data_buffer
  localparam logic [7:0] ADR_BRK   = 8'h14; // break_flag_control_reg
  localparam logic [7:0] ADR_BAUD  = 8'h18; // RT clock divisor

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C1_ENABLE  = 6;
  localparam int C1_NINE    = 4;
  localparam int C1_WAKE    = 3;
  localparam int C1_IDLE_TY = 2;
  localparam int C1_PAR_EN  = 1;
  localparam int C1_PAR_ODD = 0;
  localparam int C2_FULL_IE = 5;
  localparam int C2_IDLE_IE = 4;
  localparam int C2_RX_EN   = 2;
  localparam int C2_STANDBY = 1;
  localparam int BRK_BREAK_CLEAR_ENABLE   = 7;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [6:0]  CTRL1_RST = 7'h00;
  localparam logic [6:0]  C1_WMASK  = 7'h5F;
  localparam logic [3:0]  CTRL3_RST = 4'h0;
  localparam int          BAUD_W    = 16;
  localparam logic [15:0] BAUD_RST  = 16'h001A;

  // ----------------------------------------------------------------
  // Timing in RT cycles
  // ----------------------------------------------------------------
  localparam int         RT_PER_BIT  = 16;
  localparam int         IDLE_BITS_8 = 10;
  localparam int         IDLE_BITS_9 = 11;
  localparam logic [7:0] IDLE_LAST_8 = 8'(IDLE_BITS_8 * RT_PER_BIT - 1);
  localparam logic [7:0] IDLE_LAST_9 = 8'(IDLE_BITS_9 * RT_PER_BIT - 1);
  localparam logic [3:0] RT_S3       = 4'h2;
  localparam logic [3:0] RT_S5       = 4'h4;
  localparam logic [3:0] RT_S7       = 4'h6;
  localparam logic [3:0] RT_S8       = 4'h7;
  localparam logic [3:0] RT_S9       = 4'h8;
  localparam logic [3:0] RT_S10      = 4'h9;
  localparam logic [3:0] RT_LAST     = 4'hF;
  localparam logic [3:0] STOP_IDX_8  = 4'h9;
  localparam logic [3:0] STOP_IDX_9  = 4'hA;
  localparam logic [7:0] STOP_RT_8   =
    8'(int'(STOP_IDX_8) * RT_PER_BIT + int'(RT_S10) + 1);
  localparam logic [7:0] STOP_RT_9   =
    8'(int'(STOP_IDX_9) * RT_PER_BIT + int'(RT_S10) + 1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    URX_SEARCH = 2'b00,
    URX_START  = 2'b01,
    URX_FRAME  = 2'b10
  } urx_state_t;

  typedef struct packed {
    logic rx_full;
    logic idle;
    logic overrun;
    logic noise;
    logic framing;
    logic parity;
  } urx_flags_t;

endpackage : urx_pkg

// >>> test/urx_tx_model.sv
`timescale 1ns/1ps

// ------------------------------------------------
// Remote transmitter on the receive line
// ------------------------------------------------
module urx_tx_model #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic clk_i,
  output logic      line_o
);
  // The line rests high between frames, like any idle serial line.
  initial line_o = 1'b1;

  // framing at matched rate
  // The stop level is a choice so a scenario can break the frame.
  task automatic send(input logic [8:0] d, input int nb, input logic stp);
    @(posedge clk_i);
    line_o <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk_i);
    for (int i = 0; i < nb; i++) begin
      line_o <= d[i];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
    line_o <= stp;
    repeat (BIT_CLKS) @(posedge clk_i);
    line_o <= 1'b1;
  endtask : send
endmodule : urx_tx_model

// >>> test/tb_urx_core.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: %h %h", $time, (a), (b)); end end

// ------------------------------------------------
// Bench for the receiver core
// ------------------------------------------------
module tb_urx_core;
  import urx_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, rdat, q;
  logic        ack, line, rx_irq, err_irq, wake, tx_oe, rx_oe;
  logic        brk = 1'b0, stp = 1'b0;
  int          n_fail = 0, n_checks = 0;

  always #10 clk_i = ~clk_i;

  // Baud divisor 1 gives an RT tick every 2 clocks, 32 clocks a bit.
  urx_tx_model #(.BIT_CLKS(32)) i_urx_tx_model (.clk_i(clk_i),
    .line_o(line));
  urx_core i_urx_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .receive_pin_i(line), .port_dir_i(2'b10), .stop_mode_i(stp),
    .debug_break_i(brk), .rx_irq_o(rx_irq), .err_irq_o(err_irq),
    .wait_wake_o(wake), .transmit_pin_oe_o(tx_oe),
    .receive_pin_oe_o(rx_oe));

  // One classic cycle; the request holds until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb

  task automatic frame(input logic [8:0] d, input int nb, input logic s);
    i_urx_tx_model.send(d, nb, s);
    repeat (8) @(posedge clk_i);
  endtask : frame

  task automatic t_setup();
    wb(0, ADR_BAUD, 0); `CHK(q[15:0], BAUD_RST)
    wb(0, 8'h1C, 0); `CHK(q, 32'h0)
    `CHK({tx_oe, rx_oe}, 2'b01)
    wb(1, ADR_BAUD, 32'h1); wb(1, ADR_CTRL1, 32'h40);
    repeat (2) @(posedge clk_i);
    `CHK({tx_oe, rx_oe}, 2'b10)
    wb(1, ADR_CTRL2, 32'h24); wb(1, ADR_CTRL3, 32'hF);
  endtask : t_setup

  task automatic t_rx();
    frame(9'h0A5, 8, 1'b1);
    `CHK(rx_irq, 1'b1)
    `CHK(wake, 1'b1)
    wb(0, ADR_STAT, 0); `CHK(q[5], 1'b1)
    wb(0, ADR_DATA, 0); `CHK(q[7:0], 8'hA5)
    repeat (3) @(posedge clk_i);
    `CHK(rx_irq, 1'b0)
  endtask : t_rx

  task automatic t_overrun();
    i_urx_tx_model.send(9'h011, 8, 1'b1);
    frame(9'h022, 8, 1'b1);
    `CHK(err_irq, 1'b1)
    wb(0, ADR_STAT, 0); `CHK(q[3], 1'b1)
    wb(0, ADR_DATA, 0); `CHK(q[7:0], 8'h11)
    repeat (3) @(posedge clk_i);
    `CHK(err_irq, 1'b0)
  endtask : t_overrun

  // A bad frame must raise its own flag and the error request.
  task automatic t_err(input logic [31:0] c1, input logic [8:0] d,
                       input logic s, input int b);
    wb(1, ADR_CTRL1, c1);
    frame(d, 8, s);
    `CHK(err_irq, 1'b1)
    wb(0, ADR_STAT, 0); `CHK(q[b], 1'b1)
    wb(0, ADR_DATA, 0);
  endtask : t_err

  // Flags hold through a protected break and clear after it.
  task automatic t_break();
    frame(9'h03C, 8, 1'b1);
    wb(0, ADR_STAT, 0); brk <= 1'b1;
    wb(0, ADR_DATA, 0); wb(0, ADR_STAT, 0); `CHK(q[5], 1'b1)
    brk <= 1'b0;
    wb(0, ADR_DATA, 0); wb(0, ADR_STAT, 0); `CHK(q[5], 1'b0)
    wb(1, ADR_BRK, 32'h80); frame(9'h03C, 8, 1'b1);
    brk <= 1'b1; wb(0, ADR_STAT, 0); wb(0, ADR_DATA, 0); brk <= 1'b0;
    wb(0, ADR_STAT, 0); `CHK(q[5], 1'b0)
  endtask : t_break

  // Stop mode in mid-frame freezes the receiver; registers survive.
  task automatic t_stop();
    fork
      i_urx_tx_model.send(9'h0F0, 8, 1'b1);
      begin
        repeat (100) @(posedge clk_i);
        stp <= 1'b1;
        wb(0, ADR_CTRL1, 0); `CHK(q[6:0], 7'h40)
        repeat (20) @(posedge clk_i);
        stp <= 1'b0;
      end
    join
    repeat (8) @(posedge clk_i);
  endtask : t_stop

  task automatic t_standby();
    wb(1, ADR_CTRL1, 32'h58); wb(1, ADR_CTRL2, 32'h26);
    frame(9'h055, 9, 1'b1);
    `CHK(rx_irq, 1'b0)
    wb(0, ADR_STAT, 0); `CHK(q[5], 1'b0)
    frame(9'h1AA, 9, 1'b1);
    wb(0, ADR_CTRL2, 0); `CHK(q[1], 1'b0)
    wb(0, ADR_STAT, 0); `CHK(q[5], 1'b1)
    wb(0, ADR_DATA, 0); `CHK(q[8:0], 9'h1AA)
    // The line must have been high for a whole idle character first.
    repeat (400) @(posedge clk_i);
    wb(1, ADR_CTRL1, 32'h40); wb(1, ADR_CTRL2, 32'h26);
    repeat (4) @(posedge clk_i);
    wb(0, ADR_CTRL2, 0); `CHK(q[1], 1'b0)
    // Clear idle, sleep through a plain character, then wake on idle.
    wb(0, ADR_STAT, 0); wb(0, ADR_DATA, 0);
    wb(1, ADR_CTRL1, 32'h48); wb(1, ADR_CTRL2, 32'h26);
    frame(9'h011, 8, 1'b1);
    wb(1, ADR_CTRL1, 32'h40);
    repeat (400) @(posedge clk_i);
    wb(0, ADR_CTRL2, 0); `CHK(q[1], 1'b0)
    wb(0, ADR_STAT, 0); `CHK(q[5:4], 2'b00)
  endtask : t_standby

  task automatic report_and_stop();
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_setup();
    t_rx();
    t_overrun();
    t_err(32'h40, 9'h055, 1'b0, 1);
    t_err(32'h42, 9'h001, 1'b1, 0);
    t_break();
    t_standby();
    t_stop();
    report_and_stop();
  end

  // The scenarios need about 4600 clocks; this cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    report_and_stop();
  end
endmodule : tb_urx_core
